// ===== hdl/pfsel_pin_mux.sv
// Per-pin output and enable multiplexer of the port F low pins
`timescale 1ns/10ps
module pfsel_pin_mux
   import pfsel_pkg::*;
(
   pfsel_mux_if.mux mx
);

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pin
         always_comb begin
            case (mx.func[g])
               PFSEL_FN_STROBE: begin
                  mx.pin_out[g] = mx.strobe[g];
                  mx.pin_oe[g] = 1'b1;
               end
               PFSEL_FN_STALL: begin
                  // Input function: direction bit ignored
                  mx.pin_out[g] = 1'b0;
                  mx.pin_oe[g] = 1'b0;
               end
               default: begin
                  // General port: direction bit picks input or output
                  mx.pin_out[g] = mx.data[g];
                  mx.pin_oe[g] = mx.dir[g];
               end
            endcase
         end
      end
   endgenerate

endmodule

// ===== hdl/pfsel_top.sv
// Port F low pin function selector with APB register slave
// Functional notes
// - Pin 2 drives the lower column strobe when expanded or expansion-enabled and any DRAM area 2-5 is 16-bit.
// - Pin 2 feeds interrupt channel 15 whenever its source select bit is 0, whatever its other function.
// - Pin 1 drives the upper column strobe when expanded or expansion-enabled and any area 2-5 is DRAM.
// - Pin 1 feeds interrupt channel 14 whenever its source select bit is 0, alongside its other function.
// - Pin 0 is the bus stall request input when the stall enable is 1 and the mode is expanded or enabled.
// - Single-chip-capable modes with expansion disabled make all three pins plain ports.
// - As a general port a pin is input with direction 0 and output with 1; bus functions ignore it.
// - The pin-state register reads the data bit where the direction bit is 1 and the pin level where it is 0, whatever the pin function.
// - The output data register holds the general output levels, resets to 0 and is read/write.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "pfsel_regs.svh"
module pfsel_top
   import pfsel_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [2:0] mode_i,
   input wire logic lower_column_strobe_i,
   input wire logic upper_column_strobe_i,
   input wire logic [2:0] pin_i,
   output logic [2:0] pin_o,
   output logic [2:0] pin_oe_o,
   output logic bus_stall_req_o,
   output logic ext_irq_ch15_n_o,
   output logic ext_irq_ch14_n_o,
   output logic [5:0] pin_func_o
);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Areas 2..(1+sel) are DRAM space; codes above 4 cover areas 2 to 5
   function automatic logic area_is_dram(input logic [2:0] sel, input int area);
      logic [2:0] top;
      top = (sel > 3'h4) ? 3'h4 : sel;
      area_is_dram = (sel != 3'h0) && ((area - 2) < int'(top));
   endfunction

   function automatic logic is_single_chip_mode(input logic [2:0] mode);
      is_single_chip_mode = (mode == `PFSEL_MODE_SC_A) || (mode == `PFSEL_MODE_SC_B);
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   pfsel_pins_t dir_r;
   pfsel_pins_t data_r;
   logic external_expansion_enable_r;
   logic [2:0] dram_sel_r;
   logic [3:0] width_r;
   logic [1:0] irqsel_r;
   logic stall_en_r;
   logic [2:0] mode_r;
   logic mode_taken_r;

   logic wr_en;
   logic setup;
   logic [31:0] rdata_nxt;
   logic err_nxt;
   pfsel_pins_t state_val;
   pfsel_func_t fn2;
   pfsel_func_t fn1;
   pfsel_func_t fn0;
   logic bus_on;
   logic any_dram;
   logic any_dram16;

   pfsel_mux_if mx ();

   assign setup = psel_i && !penable_i;
   // Writes commit only in the access cycle that carries the answer
   assign wr_en = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o && pstrb_i[0];

   // ----------------------------------------
   // Operating mode capture after reset release
   // ----------------------------------------
   // Mode pins are read once, on the edge after reset leaves
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r <= 3'h0;
         mode_taken_r <= 1'b0;
      end else if (!mode_taken_r) begin
         mode_r <= mode_i;
         mode_taken_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Port direction and output data
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dir_r <= `PFSEL_DIR_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_DIR) begin
         dir_r <= pwdata_i[2:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_r <= `PFSEL_DATA_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_DATA) begin
         data_r <= pwdata_i[2:0];
      end
   end

   // ----------------------------------------
   // Bus controller and interrupt settings
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         external_expansion_enable_r <= `PFSEL_EXTERNAL_EXPANSION_ENABLE_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_EXPAND) begin
         external_expansion_enable_r <= pwdata_i[`PFSEL_EXTERNAL_EXPANSION_ENABLE_BIT];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dram_sel_r <= `PFSEL_DRAM_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_DRAM) begin
         dram_sel_r <= pwdata_i[`PFSEL_DRAM_SEL_W-1:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         width_r <= `PFSEL_WIDTH_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_WIDTH) begin
         width_r <= pwdata_i[`PFSEL_WIDTH_W-1:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irqsel_r <= `PFSEL_IRQSEL_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_IRQSEL) begin
         irqsel_r <= pwdata_i[1:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stall_en_r <= `PFSEL_STALL_EN_RST;
      end else if (wr_en && paddr_i == `PFSEL_OFS_BUSCTL) begin
         stall_en_r <= pwdata_i[`PFSEL_STALL_EN_BIT];
      end
   end

   // ----------------------------------------
   // Pin function selection
   // ----------------------------------------
   always_comb begin
      any_dram = 1'b0;
      any_dram16 = 1'b0;
      for (int a = 2; a <= 5; a++) begin
         if (area_is_dram(dram_sel_r, a)) begin
            any_dram = 1'b1;
            // A clear width bit marks a 16-bit area
            if (!width_r[a-2]) begin
               any_dram16 = 1'b1;
            end
         end
      end
   end

   // Bus functions need an expanded mode or expansion enabled
   assign bus_on = !is_single_chip_mode(mode_r) || external_expansion_enable_r;

   // Strobe and stall functions outrank the direction bits
   always_comb begin
      fn2 = PFSEL_FN_GPIO;
      fn1 = PFSEL_FN_GPIO;
      fn0 = PFSEL_FN_GPIO;
      if (bus_on && any_dram16) begin
         fn2 = PFSEL_FN_STROBE;
      end
      if (bus_on && any_dram) begin
         fn1 = PFSEL_FN_STROBE;
      end
      if (bus_on && stall_en_r) begin
         fn0 = PFSEL_FN_STALL;
      end
   end

   assign mx.func[2] = fn2;
   assign mx.func[1] = fn1;
   assign mx.func[0] = fn0;
   assign mx.dir = dir_r;
   assign mx.data = data_r;
   // Pin 0 has no strobe to carry
   assign mx.strobe = {lower_column_strobe_i, upper_column_strobe_i, 1'b0};

   pfsel_pin_mux u_mux (
      .mx(mx)
   );

   // ----------------------------------------
   // Pin drivers and side outputs
   // ----------------------------------------
   // Registered so every pin and side output changes on a clean edge
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_o <= 3'h0;
         pin_oe_o <= 3'h0;
      end else begin
         pin_o <= mx.pin_out;
         pin_oe_o <= mx.pin_oe;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_stall_req_o <= 1'b0;
      end else begin
         // Stall line is active low at the pin
         bus_stall_req_o <= (fn0 == PFSEL_FN_STALL) && !pin_i[0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_irq_ch15_n_o <= 1'b1;
         ext_irq_ch14_n_o <= 1'b1;
      end else begin
         // Pin level passes whatever the pin function; idle high when deselected
         ext_irq_ch15_n_o <= irqsel_r[`PFSEL_EXT_IRQ_CH15_BIT] ? 1'b1 : pin_i[2];
         ext_irq_ch14_n_o <= irqsel_r[`PFSEL_EXT_IRQ_CH14_BIT] ? 1'b1 : pin_i[1];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_func_o <= 6'h00;
      end else begin
         pin_func_o <= {fn2, fn1, fn0};
      end
   end

   // ----------------------------------------
   // APB read decode
   // ----------------------------------------
   // Bus functions leave the state read to the direction bit
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_state
         assign state_val[g] = dir_r[g] ? data_r[g] : pin_i[g];
      end
   endgenerate

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr_i)
         `PFSEL_OFS_DIR: rdata_nxt[2:0] = dir_r;
         `PFSEL_OFS_DATA: rdata_nxt[2:0] = data_r;
         `PFSEL_OFS_STATE: begin
            rdata_nxt[2:0] = state_val;
         end
         `PFSEL_OFS_EXPAND: rdata_nxt[`PFSEL_EXTERNAL_EXPANSION_ENABLE_BIT] = external_expansion_enable_r;
         `PFSEL_OFS_DRAM: rdata_nxt[2:0] = dram_sel_r;
         `PFSEL_OFS_WIDTH: rdata_nxt[3:0] = width_r;
         `PFSEL_OFS_IRQSEL: rdata_nxt[1:0] = irqsel_r;
         `PFSEL_OFS_BUSCTL: rdata_nxt[`PFSEL_STALL_EN_BIT] = stall_en_r;
         `PFSEL_OFS_FUNC: rdata_nxt[8:0] = {mode_r, fn2, fn1, fn0};
         default: err_nxt = 1'b1;
      endcase
      if (pwrite_i && (paddr_i == `PFSEL_OFS_STATE || paddr_i == `PFSEL_OFS_FUNC)) begin
         // Status registers cannot be written
         err_nxt = 1'b1;
      end
   end

   // Answer in the first access cycle; read data taken during setup
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= setup;
         if (setup) begin
            pslverr_o <= err_nxt;
            prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

endmodule

// ===== shared/pfsel_mux_if.sv
// Carrier between the selector control and its pin multiplexer
`timescale 1ns/10ps
interface pfsel_mux_if;
   import pfsel_pkg::*;

   pfsel_func_t func [3];
   pfsel_pins_t dir;
   pfsel_pins_t data;
   pfsel_pins_t strobe;
   pfsel_pins_t pin_out;
   pfsel_pins_t pin_oe;

   modport ctrl (
      output func,
      output dir,
      output data,
      output strobe,
      input pin_out,
      input pin_oe
   );

   modport mux (
      input func,
      input dir,
      input data,
      input strobe,
      output pin_out,
      output pin_oe
   );
endinterface

// ===== shared/pfsel_pkg.sv
// Types shared by the port F low pin selector
package pfsel_pkg;

   typedef logic [2:0] pfsel_pins_t;

   typedef enum logic [1:0] {
      PFSEL_FN_GPIO,
      PFSEL_FN_STROBE,
      PFSEL_FN_STALL
   } pfsel_func_t;

endpackage

// ===== shared/pfsel_regs.svh
// Register offsets, field positions and reset values of the port F low pin selector
`ifndef PFSEL_REGS_SVH
`define PFSEL_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PFSEL_OFS_DIR 8'h00
`define PFSEL_OFS_DATA 8'h04
`define PFSEL_OFS_STATE 8'h08
`define PFSEL_OFS_EXPAND 8'h0C
`define PFSEL_OFS_DRAM 8'h10
`define PFSEL_OFS_WIDTH 8'h14
`define PFSEL_OFS_IRQSEL 8'h18
`define PFSEL_OFS_BUSCTL 8'h1C
`define PFSEL_OFS_FUNC 8'h20

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define PFSEL_PIN_CNT 3
`define PFSEL_EXTERNAL_EXPANSION_ENABLE_BIT 0
`define PFSEL_DRAM_SEL_W 3
`define PFSEL_WIDTH_W 4
`define PFSEL_EXT_IRQ_CH14_BIT 0
`define PFSEL_EXT_IRQ_CH15_BIT 1
`define PFSEL_STALL_EN_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PFSEL_DIR_RST 3'h0
`define PFSEL_DATA_RST 3'h0
`define PFSEL_EXTERNAL_EXPANSION_ENABLE_RST 1'h0
`define PFSEL_DRAM_RST 3'h0
`define PFSEL_WIDTH_RST 4'hF
`define PFSEL_IRQSEL_RST 2'h3
`define PFSEL_STALL_EN_RST 1'h0

// ----------------------------------------
// Operating modes that can run single-chip
// ----------------------------------------
`define PFSEL_MODE_SC_A 3'h3
`define PFSEL_MODE_SC_B 3'h7

`endif

// ===== test/pfsel_board_model.sv
// Board side of the three pins: pull-ups and an external driver
`timescale 1ns/10ps
module pfsel_board_model (
   input wire logic [2:0] dev_out_i,
   input wire logic [2:0] dev_oe_i,
   input wire logic [2:0] ext_en_i,
   input wire logic [2:0] ext_val_i,
   output logic [2:0] level_o
);
   // Undriven lines float up to the pull-up level
   assign level_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule

// ===== test/pfsel_properties.sv
// Port-level checks of the port F low pin selector
`timescale 1ns/10ps
module pfsel_properties (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [2:0] pin_i,
   input wire logic lower_column_strobe_i,
   input wire logic upper_column_strobe_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe_o,
   input wire logic bus_stall_req_o,
   input wire logic ext_irq_ch15_n_o,
   input wire logic ext_irq_ch14_n_o,
   input wire logic [5:0] pin_func_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   setup_answer_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no answer after setup");
   answer_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("answer held too long");
   ext_irq_ch15_source_a: assert property (!ext_irq_ch15_n_o |-> !$past(pin_i[2]))
      else $error("ch15 request without low pin");
   ext_irq_ch14_source_a: assert property (!ext_irq_ch14_n_o |-> !$past(pin_i[1]))
      else $error("ch14 request without low pin");
   stall_request_a: assert property (bus_stall_req_o == (pin_func_o[1:0] == 2'h2 && !$past(pin_i[0])))
      else $error("stall request mismatch");
   stall_undriven_a: assert property (pin_func_o[1:0] == 2'h2 |-> !pin_oe_o[0])
      else $error("stall pin driven");
   lower_strobe_a: assert property (pin_func_o[5:4] == 2'h1 |-> pin_oe_o[2] && pin_o[2] == $past(lower_column_strobe_i))
      else $error("lower strobe not passed");
   upper_strobe_a: assert property (pin_func_o[3:2] == 2'h1 |-> pin_oe_o[1] && pin_o[1] == $past(upper_column_strobe_i))
      else $error("upper strobe not passed");
   cover property (pin_func_o[5:4] == 2'h1);
   cover property (bus_stall_req_o);
   cover property (!ext_irq_ch15_n_o);
   cover property (pslverr_o);
endmodule

// ===== test/tb_top.sv
// Self-checking bench of the port F low pin selector
`timescale 1ns/10ps
module tb_top;
   logic clock_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, bus_stall_req_o;
   logic lower_column_strobe_i, upper_column_strobe_i, ext_irq_ch15_n_o, ext_irq_ch14_n_o, err, external_expansion_enable, sen;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rdat, r;
   logic [3:0] pstrb_i, wid;
   logic [2:0] mode_i, pin_i, pin_o, pin_oe_o, dir, data, dsel, xen, xval, eoe, eout, lvl;
   logic [1:0] isel;
   logic [5:0] pin_func_o, f;
   int miscompares = 0;
   int tests_run = 0;
   logic [2:0] mtab [4] = '{3'h0, 3'h3, 3'h7, 3'h5};
   logic [31:0] rtab [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hF, 32'h3, 32'h0};

   pfsel_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_i(mode_i), .lower_column_strobe_i(lower_column_strobe_i),
      .upper_column_strobe_i(upper_column_strobe_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
      .bus_stall_req_o(bus_stall_req_o), .ext_irq_ch15_n_o(ext_irq_ch15_n_o),
      .ext_irq_ch14_n_o(ext_irq_ch14_n_o), .pin_func_o(pin_func_o));
   pfsel_board_model board (.dev_out_i(pin_o), .dev_oe_i(pin_oe_o), .ext_en_i(xen), .ext_val_i(xval),
      .level_o(pin_i));

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [5:0] exp_fn();
      logic ex;
      logic [3:0] am;
      ex = !(mode_i == 3'h3 || mode_i == 3'h7) || external_expansion_enable;
      am = dsel == 3'h0 ? 4'h0 : dsel >= 3'h4 ? 4'hF : 4'hF >> (3'h4 - dsel);
      return {2'(ex && |(am & ~wid)), 2'(ex && am != 4'h0), (ex && sen) ? 2'h2 : 2'h0};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      // Request stands until the answer is seen at a rising edge
      while (pready_o !== 1'b1) begin
         @(posedge clock_i);
      end
      rdat = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic complete_run();
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, mode_i} = '0;
      {lower_column_strobe_i, upper_column_strobe_i, xen, xval} = '0;
      pstrb_i = 4'hF;
      r = 32'h160A;
      foreach (mtab[m]) begin
         mode_i <= mtab[m];
         rst_n_i <= 1'b0;
         repeat (16) @(posedge clock_i);
         rst_n_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         if (m == 0) begin
            for (int i = 0; i < 8; i++) begin
               apb(1'b0, 8'(i * 4), 32'h0);
               if (i != 2) chk(rdat, rtab[i]);
            end
            apb(1'b1, 8'h08, 32'h7);
            chk(32'(err), 32'h1);
            apb(1'b0, 8'h24, 32'h0);
            chk(32'(err), 32'h1);
         end
         for (int k = 0; k < 30; k++) begin
            r = lfsr(r);
            {sen, isel, wid, dsel, external_expansion_enable, data, dir} = r[16:0];
            apb(1'b1, 8'h00, 32'(dir));
            apb(1'b1, 8'h04, 32'(data));
            apb(1'b1, 8'h0C, 32'(external_expansion_enable));
            apb(1'b1, 8'h10, 32'(dsel));
            apb(1'b1, 8'h14, 32'(wid));
            apb(1'b1, 8'h18, 32'(isel));
            apb(1'b1, 8'h1C, 32'(sen));
            lower_column_strobe_i <= r[23];
            upper_column_strobe_i <= r[24];
            {xval, xen} <= r[22:17];
            @(posedge clock_i);
            @(negedge clock_i);
            f = exp_fn();
            chk(32'(pin_func_o), 32'(f));
            @(posedge clock_i);
            @(negedge clock_i);
            eoe = {f[5:4] != 2'h0 | dir[2], f[3:2] != 2'h0 | dir[1], f[1:0] == 2'h0 & dir[0]};
            eout = {f[4] ? r[23] : data[2], f[2] ? r[24] : data[1], data[0]};
            lvl = (eoe & eout) | (~eoe & ((r[19:17] & r[22:20]) | ~r[19:17]));
            chk(32'(pin_func_o), 32'(f));
            chk(32'(pin_oe_o), 32'(eoe));
            chk(32'(pin_o & eoe), 32'(eout & eoe));
            chk(32'({ext_irq_ch15_n_o, ext_irq_ch14_n_o}), 32'({isel[1] | lvl[2], isel[0] | lvl[1]}));
            chk(32'(bus_stall_req_o), 32'(f[1] & ~lvl[0]));
            apb(1'b0, 8'h08, 32'h0);
            chk(rdat, 32'((dir & data) | (~dir & lvl)));
            apb(1'b0, 8'h20, 32'h0);
            chk(rdat, 32'({mode_i, f}));
         end
      end
      complete_run();
   end

   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule

bind pfsel_top pfsel_properties u_props (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pin_i(pin_i), .lower_column_strobe_i(lower_column_strobe_i),
   .upper_column_strobe_i(upper_column_strobe_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .bus_stall_req_o(bus_stall_req_o),
   .ext_irq_ch15_n_o(ext_irq_ch15_n_o), .ext_irq_ch14_n_o(ext_irq_ch14_n_o), .pin_func_o(pin_func_o));
